// file: core/tsb_bridge.sv
// timeslot selection, channel bridging and signaling drop for eight trunks
// How it works
// - each trunk is a stream of timeslots, 24 channels in T1, 31 in E1.
// - every channel has its own timeslot; any may become a signaling link.
// - no more than 64 signaling links are selected over all eight ports.
// - after reset sixteen links are selected until provisioning changes it.
// - ports 1-4 form backplane interface A, ports 5-8 interface B.
// - one line format, E1 or T1, applies to all ports of the card.
// - a bridged master hands its non-signaling timeslots to its even partner.
// - master transmit merges own signaling octets with pass-through data.
// - bridging only works while the card runs in channelized mode.
// - slave slots taken from the master carry the card's own idle pattern.
// - signaling selection on a bridged slave port is refused.
// - ports pair odd with next even; bridged signaling only on odd ports.
// - slave receive data leaves through the master port as well.
// - each odd port has its own bridge enable, any mix at once.
// - non-signaling slots on bridged ports pass unchanged as active data.
// - both ports of a bridged pair run from one common link clock.
`timescale 1ns/1ps
`default_nettype none

// small synchronous fifo of flip-flops
module tsb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] level;
    logic push;
    logic pop;

    // flags straight from the level count, so full and empty are exact
    assign o_in_ready = level != (AW+1)'(DEPTH);
    assign o_out_valid = level != '0;
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // storage write
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers and level
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module tsb_bridge (
    // system clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // card configuration
    input wire logic i_e1_mode,
    input wire logic i_channelized,
    input wire logic [3:0] i_bridge_en,
    // signaling selection writes
    input wire logic i_map_wr,
    input wire logic [2:0] i_map_port,
    input wire logic [4:0] i_map_chan,
    input wire logic i_map_set,
    output logic o_map_ack,
    output logic o_map_refused,
    // configuration status
    output logic o_cfg_busy,
    output logic [6:0] o_link_count,
    output logic [1:0] o_iface_active,
    output logic [3:0] o_bridge_active,
    // dropped signaling octets toward the processor
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic [7:0] o_rx_data,
    output logic [2:0] o_rx_port,
    output logic [4:0] o_rx_slot,
    output logic o_rx_overflow,
    // trunk side, all on the common line clock
    input wire logic i_lclk,
    input wire logic i_frame_start,
    input wire logic i_ts_strobe,
    input wire logic [63:0] i_rx_octets,
    output logic [63:0] o_tx_octets,
    // transmit signaling octets, same clock as the trunks
    output logic [7:0] o_sig_take,
    input wire logic [63:0] i_sig_octets
);
    // system-side selection map and shadow handed to the line side
    logic [30:0] map [tsb_pkg::NUM_PORTS];
    logic [30:0] shadow_map [tsb_pkg::NUM_PORTS];
    logic shadow_e1;
    logic [3:0] shadow_br;
    logic [6:0] link_count;
    logic map_dirty;
    logic req_tgl;
    logic ak1, ak2, ak3, ack_st;
    logic [3:0] bridge_eff;
    logic map_hit, wr_ok, take_snap;
    logic [4:0] chan_lim;
    // line-side copies and datapath
    logic lr1, lr2, lr3, lrun;
    logic rq1, rq2, rq3, req_seen;
    logic [30:0] lmap [tsb_pkg::NUM_PORTS];
    logic le1;
    logic [3:0] lbr;
    logic [4:0] slot, cur_slot, chan;
    logic in_rng;
    logic [7:0] sig_eff;
    logic [7:0] pend;
    logic [7:0] pend_oct [tsb_pkg::NUM_PORTS];
    logic [4:0] pend_slot;
    logic [7:0] push_bit;
    logic [2:0] push_port;
    logic ovf;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [15:0] f_out_data, xword;
    logic xreq, xa1, xa2, xa3, xack_st;
    // system-side delivery
    logic xr1, xr2, xr3, xseen, xack;
    logic of1, of2, of3;
    tsb_pkg::tsb_rx_state_type rx_state;

    // bridging only takes effect in channelized mode
    assign bridge_eff = i_bridge_en & {4{i_channelized}};
    assign o_bridge_active = bridge_eff;
    assign chan_lim = i_e1_mode ? tsb_pkg::E1_CHANNELS
                                : tsb_pkg::T1_CHANNELS;
    assign map_hit = (i_map_chan < chan_lim) && map[i_map_port][i_map_chan];
    // refuse slave-port selections on a bridged pair, out-of-range channels
    // and any selection past the card's link budget
    assign wr_ok = (i_map_chan < chan_lim)
        && !(i_map_port[0] && bridge_eff[i_map_port[2:1]])
        && !(i_map_set && !map_hit
             && link_count == tsb_pkg::MAX_LINKS);
    assign o_map_ack = i_map_wr && wr_ok;
    assign o_map_refused = i_map_wr && !wr_ok;
    assign o_link_count = link_count;

    // selection map, one bit per channel per port
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            for (int p = 0; p < tsb_pkg::NUM_PORTS; p++)
            begin
                map[p] <= (p == 0) ? tsb_pkg::DEFAULT_MAP_PORT0
                                   : tsb_pkg::EMPTY_MAP;
            end
            link_count <= tsb_pkg::DEFAULT_LINKS;
        end
        else if (o_map_ack)
        begin
            map[i_map_port][i_map_chan] <= i_map_set;
            if (i_map_set && !map_hit)
            begin
                link_count <= link_count + 7'h01;
            end
            else if (!i_map_set && map_hit)
            begin
                link_count <= link_count - 7'h01;
            end
        end
    end

    // interface activity: ports 1-4 on A, 5-8 on B
    always_comb
    begin
        o_iface_active = 2'h0;
        for (int p = 0; p < tsb_pkg::NUM_PORTS; p++)
        begin
            if (map[p] != tsb_pkg::EMPTY_MAP)
            begin
                o_iface_active[p / tsb_pkg::PORTS_PER_IFACE] = 1'b1;
            end
        end
    end

    // snapshot towards the line side; the shadow holds still while busy,
    // which makes the multi-bit hand-over safe
    assign o_cfg_busy = req_tgl != ack_st;
    assign take_snap = !o_cfg_busy && (map_dirty || shadow_e1 != i_e1_mode
                                       || shadow_br != bridge_eff);
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            req_tgl <= 1'b0;
            map_dirty <= 1'b1;
            shadow_e1 <= 1'b0;
            shadow_br <= 4'h0;
        end
        else
        begin
            // a write in the snapshot cycle keeps the dirty mark
            map_dirty <= (map_dirty && !take_snap) || o_map_ack;
            if (take_snap)
            begin
                shadow_map <= map;
                shadow_e1 <= i_e1_mode;
                shadow_br <= bridge_eff;
                req_tgl <= !req_tgl;
            end
        end
    end

    // acknowledge toggle back from the line side
    always_ff @(posedge i_mclk)
    begin
        ak1 <= req_seen;
        ak2 <= ak1;
        ak3 <= ak2;
        if (!i_rst_n)
        begin
            ack_st <= 1'b0;
        end
        else if (ak2 == ak3)
        begin
            ack_st <= ak3;
        end
    end

    // line-side reset follows the system reset through a synchroniser
    always_ff @(posedge i_lclk)
    begin
        lr1 <= i_rst_n;
        lr2 <= lr1;
        lr3 <= lr2;
        if (lr2 && lr3)
        begin
            lrun <= 1'b1;
        end
        else if (!lr2 && !lr3)
        begin
            lrun <= 1'b0;
        end
    end

    // configuration taken over on the line clock when the request toggles
    always_ff @(posedge i_lclk)
    begin
        rq1 <= req_tgl;
        rq2 <= rq1;
        rq3 <= rq2;
        if (!lrun)
        begin
            req_seen <= 1'b0;
            le1 <= 1'b0;
            lbr <= 4'h0;
            for (int p = 0; p < tsb_pkg::NUM_PORTS; p++)
            begin
                lmap[p] <= tsb_pkg::EMPTY_MAP;
            end
        end
        else if (rq2 == rq3 && rq3 != req_seen)
        begin
            req_seen <= rq3;
            lmap <= shadow_map;
            le1 <= shadow_e1;
            lbr <= shadow_br;
        end
    end

    // timeslot of the octets presented with this strobe
    assign cur_slot = i_frame_start ? 5'h00 : slot + 5'h01;
    assign chan = le1 ? cur_slot - 5'h01 : cur_slot;
    assign in_rng = le1 ? (cur_slot != 5'h00)
                        : (cur_slot < tsb_pkg::T1_CHANNELS);
    always_comb
    begin
        sig_eff = 8'h00;
        for (int p = 0; p < tsb_pkg::NUM_PORTS; p++)
        begin
            // a bridged slave never drops a slot for signaling
            sig_eff[p] = in_rng && lmap[p][chan]
                         && !(p % 2 == 1 && lbr[p / 2]);
        end
    end
    assign o_sig_take = i_ts_strobe ? sig_eff : 8'h00;

    // slot counter, realigned by each frame start
    always_ff @(posedge i_lclk)
    begin
        if (!lrun)
        begin
            slot <= 5'h1F;
        end
        else if (i_ts_strobe)
        begin
            slot <= cur_slot;
        end
    end

    // transmit octets change only on a strobe, so a whole octet always
    // belongs to one slot; both ports of a pair share this one clock
    always_ff @(posedge i_lclk)
    begin
        if (!lrun)
        begin
            o_tx_octets <= {8{tsb_pkg::IDLE_OCTET}};
        end
        else if (i_ts_strobe)
        begin
            for (int k = 0; k < tsb_pkg::NUM_PAIRS; k++)
            begin
                // odd master: own signaling merged with slave pass-through
                if (sig_eff[2*k])
                begin
                    o_tx_octets[16*k +: 8] <= i_sig_octets[16*k +: 8];
                end
                else if (lbr[k])
                begin
                    o_tx_octets[16*k +: 8] <=
                        i_rx_octets[16*k+8 +: 8];
                end
                else
                begin
                    o_tx_octets[16*k +: 8] <= tsb_pkg::IDLE_OCTET;
                end
                // even slave: master data or idle in slots taken for signaling
                if (lbr[k])
                begin
                    o_tx_octets[16*k+8 +: 8] <= sig_eff[2*k]
                        ? tsb_pkg::IDLE_OCTET
                        : i_rx_octets[16*k +: 8];
                end
                else if (sig_eff[2*k+1])
                begin
                    o_tx_octets[16*k+8 +: 8] <= i_sig_octets[16*k+8 +: 8];
                end
                else
                begin
                    o_tx_octets[16*k+8 +: 8] <= tsb_pkg::IDLE_OCTET;
                end
            end
        end
    end

    // lowest pending port goes to the fifo first
    always_comb
    begin
        push_bit = 8'h00;
        push_port = 3'h0;
        for (int p = tsb_pkg::NUM_PORTS - 1; p >= 0; p--)
        begin
            if (pend[p])
            begin
                push_bit = 8'h01 << p;
                push_port = 3'(p);
            end
        end
    end

    // dropped octets wait here one slot; a full fifo stalls the drain and
    // anything still waiting at the next strobe is lost, and flagged unless a single octet waits while the fifo has room
    always_ff @(posedge i_lclk)
    begin
        if (!lrun)
        begin
            pend <= 8'h00;
            pend_slot <= 5'h00;
            ovf <= 1'b0;
        end
        else if (i_ts_strobe)
        begin
            pend <= sig_eff;
            pend_slot <= cur_slot;
            for (int p = 0; p < tsb_pkg::NUM_PORTS; p++)
            begin
                pend_oct[p] <= i_rx_octets[8*p +: 8];
            end
            if ((pend & ~(f_in_ready ? push_bit : 8'h00)) != 8'h00)
            begin
                ovf <= 1'b1;
            end
        end
        else if (f_in_ready)
        begin
            pend <= pend & ~push_bit;
        end
    end

    tsb_fifo #(
        .WIDTH(tsb_pkg::FIFO_W),
        .DEPTH(tsb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_lclk),
        .i_rst_n(lrun),
        .i_in_valid(pend != 8'h00 && !i_ts_strobe),
        .o_in_ready(f_in_ready),
        .i_in_data({pend_slot, push_port, pend_oct[push_port]}),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_out_ready),
        .o_out_data(f_out_data)
    );

    // one word at a time crosses to the system clock by toggle handshake
    assign f_out_ready = xreq == xack_st;
    always_ff @(posedge i_lclk)
    begin
        xa1 <= xack;
        xa2 <= xa1;
        xa3 <= xa2;
        if (!lrun)
        begin
            xreq <= 1'b0;
            xack_st <= 1'b0;
            xword <= 16'h0000;
        end
        else
        begin
            if (xa2 == xa3)
            begin
                xack_st <= xa3;
            end
            if (f_out_valid && f_out_ready)
            begin
                xword <= f_out_data;
                xreq <= !xreq;
            end
        end
    end

    // delivery to the processor, held until it is taken
    always_ff @(posedge i_mclk)
    begin
        xr1 <= xreq;
        xr2 <= xr1;
        xr3 <= xr2;
        of1 <= ovf;
        of2 <= of1;
        of3 <= of2;
        if (!i_rst_n)
        begin
            rx_state <= tsb_pkg::rx_wait;
            xseen <= 1'b0;
            xack <= 1'b0;
            o_rx_overflow <= 1'b0;
            o_rx_data <= 8'h00;
            o_rx_port <= 3'h0;
            o_rx_slot <= 5'h00;
        end
        else
        begin
            if (of2 && of3)
            begin
                o_rx_overflow <= 1'b1;
            end
            case (rx_state)
                tsb_pkg::rx_wait:
                begin
                    if (xr2 == xr3 && xr3 != xseen)
                    begin
                        xseen <= xr3;
                        o_rx_data <= xword[7:0];
                        o_rx_port <= xword[tsb_pkg::WORD_PORT_LSB +: 3];
                        o_rx_slot <= xword[tsb_pkg::WORD_SLOT_LSB +: 5];
                        rx_state <= tsb_pkg::rx_show;
                    end
                end
                tsb_pkg::rx_show:
                begin
                    if (i_rx_ready)
                    begin
                        xack <= xseen;
                        rx_state <= tsb_pkg::rx_wait;
                    end
                end
                default:
                begin
                    rx_state <= tsb_pkg::rx_wait;
                end
            endcase
        end
    end
    assign o_rx_valid = rx_state == tsb_pkg::rx_show;

    // checks on the system clock
    a_link_budget: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        link_count <= tsb_pkg::MAX_LINKS)
        else $error("link count above budget");
    a_reset_default: assert property (@(posedge i_mclk)
        $rose(i_rst_n) |-> link_count == tsb_pkg::DEFAULT_LINKS)
        else $error("default link count wrong after reset");
    a_slave_refuse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_map_wr && i_map_port[0] && bridge_eff[i_map_port[2:1]])
        |-> o_map_refused ##1 $stable(link_count))
        else $error("selection accepted on bridged slave");
    a_bridge_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_channelized |-> o_bridge_active == 4'h0)
        else $error("bridging active outside channelized mode");
    a_t1_range: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_map_wr && !i_e1_mode && i_map_chan >= tsb_pkg::T1_CHANNELS)
        |-> o_map_refused)
        else $error("channel beyond T1 range accepted");
    a_rx_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_rx_valid && !i_rx_ready) |=> o_rx_valid && $stable(o_rx_data))
        else $error("received octet dropped before taken");

    // checks on the line clock
    a_idle_slave: assert property (@(posedge i_lclk) disable iff (!lrun)
        (i_ts_strobe && lbr[0] && sig_eff[0])
        |=> o_tx_octets[15:8] == tsb_pkg::IDLE_OCTET)
        else $error("taken slot on slave not idle");
    a_pass_fwd: assert property (@(posedge i_lclk) disable iff (!lrun)
        (i_ts_strobe && lbr[2] && !sig_eff[4])
        |=> o_tx_octets[47:40] == $past(i_rx_octets[39:32]))
        else $error("master data not passed to slave");
    a_pass_back: assert property (@(posedge i_lclk) disable iff (!lrun)
        (i_ts_strobe && lbr[2] && !sig_eff[4])
        |=> o_tx_octets[39:32] == $past(i_rx_octets[47:40]))
        else $error("slave data not returned by master");
    a_slot_edge: assert property (@(posedge i_lclk) disable iff (!lrun)
        ##1 !i_ts_strobe |=> $stable(o_tx_octets))
        else $error("transmit octet changed inside a slot");
    a_e1_frame_slot: assert property (@(posedge i_lclk) disable iff (!lrun)
        (le1 && i_frame_start) |-> sig_eff == 8'h00)
        else $error("E1 framing slot dropped");
endmodule

`default_nettype wire

// file: pkg/tsb_pkg.sv
// constants and types shared by the timeslot bridge design
package tsb_pkg;
    // port and pair organisation of one card
    localparam int NUM_PORTS = 8;
    localparam int NUM_PAIRS = 4;
    localparam int PORTS_PER_IFACE = 4;
    // channels per trunk format, also the map index limit
    localparam logic [4:0] T1_CHANNELS = 5'h18;
    localparam logic [4:0] E1_CHANNELS = 5'h1F;
    localparam int MAP_W = 31;
    // link budget and reset selection
    localparam logic [6:0] MAX_LINKS = 7'h40;
    localparam logic [6:0] DEFAULT_LINKS = 7'h10;
    localparam logic [30:0] DEFAULT_MAP_PORT0 = 31'h0000FFFF;
    localparam logic [30:0] EMPTY_MAP = 31'h00000000;
    // octet the card puts into timeslots it owns but has no data for
    localparam logic [7:0] IDLE_OCTET = 8'hFF;
    // received signaling word: {slot, port, octet}
    localparam int OCTET_W = 8;
    localparam int PORT_W = 3;
    localparam int SLOT_W = 5;
    localparam int WORD_PORT_LSB = 8;
    localparam int WORD_SLOT_LSB = 11;
    localparam int FIFO_W = 16;
    localparam int FIFO_DEPTH = 8;
    // delivery state on the system clock
    typedef enum logic [1:0] {
        rx_wait = 2'b01,
        rx_show = 2'b10
    } tsb_rx_state_type;
endpackage

// file: testbench/tsb_trunk_model.sv
// trunk framer model feeding timeslot strobes and octets on the line clock
`timescale 1ns/1ps
`default_nettype none
module tsb_trunk_model (
    // line clock and traffic enable
    input wire logic i_lclk,
    input wire logic i_en,
    // framed octets toward the bridge
    output logic o_frame_start,
    output logic o_ts_strobe,
    output logic [4:0] o_slot,
    output logic [63:0] o_rx_octets,
    output logic [63:0] o_sig_octets
);
    logic [5:0] div = 6'h00;
    logic [4:0] slot = 5'h17;
    logic stb = 1'b0;
    logic fs = 1'b0;
    // forty line cycles per slot: each drop needs about five line cycles
    // to cross to the system clock, so six drops per slot still keep up
    always_ff @(posedge i_lclk)
    begin
        div <= (div == 6'h27) ? 6'h00 : div + 6'h01;
        stb <= i_en && div == 6'h00;
        fs <= i_en && div == 6'h00 && slot == 5'h17;
        if (i_en && div == 6'h00)
            slot <= (slot == 5'h17) ? 5'h00 : slot + 5'h01;
    end
    assign o_ts_strobe = stb;
    assign o_frame_start = fs;
    assign o_slot = slot;
    // data in every slot; between strobes the lines show the inverse
    always_comb
        for (int p = 0; p < 8; p++)
        begin
            o_rx_octets[8*p +: 8] = {p[2:0], slot} ^ {8{!stb}};
            o_sig_octets[8*p +: 8] = {p[2:0], slot} ^ (stb ? 8'hA5 : 8'h5A);
        end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the timeslot bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_mclk = 1'b0;
    logic i_lclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_e1_mode = 1'b0;
    logic i_channelized = 1'b0;
    logic [3:0] i_bridge_en = 4'h0;
    logic i_map_wr = 1'b0;
    logic [2:0] i_map_port = 3'h0;
    logic [4:0] i_map_chan = 5'h00;
    logic i_map_set = 1'b0;
    logic i_rx_ready = 1'b0;
    logic line_en = 1'b0;
    logic stb_d = 1'b0;
    logic o_map_ack, o_map_refused, o_cfg_busy, o_rx_valid, o_rx_overflow;
    logic i_frame_start, i_ts_strobe;
    logic [6:0] o_link_count;
    logic [1:0] o_iface_active;
    logic [3:0] o_bridge_active;
    logic [7:0] o_rx_data, o_sig_take;
    logic [2:0] o_rx_port;
    logic [4:0] o_rx_slot, slot, slot_d;
    logic [63:0] i_rx_octets, o_tx_octets, i_sig_octets;
    logic [31:0] lfsr = 32'h1142;
    logic [31:0] sel [8];
    logic [15:0] exp_q [$];
    int n_fail = 0;
    int check_count = 0;
    int cnt = 16;
    // clocks with unrelated phase
    initial forever #5 i_mclk = ~i_mclk;
    initial forever #62.5 i_lclk = ~i_lclk;
    tsb_bridge u_tsb_bridge (.*);
    tsb_trunk_model u_tsb_trunk_model (.i_lclk(i_lclk), .i_en(line_en),
        .o_frame_start(i_frame_start), .o_ts_strobe(i_ts_strobe),
        .o_slot(slot), .o_rx_octets(i_rx_octets), .o_sig_octets(i_sig_octets));
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] rxo(input int p, input logic [4:0] s);
        return {p[2:0], s};
    endfunction
    // a slave of a bridged pair drops nothing, whatever its map says
    function automatic logic on(input int p, input logic [4:0] s);
        return sel[p][s] && !(p % 2 == 1 && i_channelized && i_bridge_en[p/2]);
    endfunction
    function automatic logic [7:0] txo(input int p, input logic [4:0] s);
        if (i_channelized && i_bridge_en[p/2])
            return (p % 2 == 1) ? (on(p ^ 1, s) ? 8'hFF : rxo(p ^ 1, s))
                : (on(p, s) ? rxo(p, s) ^ 8'hA5 : rxo(p ^ 1, s));
        return on(p, s) ? rxo(p, s) ^ 8'hA5 : 8'hFF;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want)
        begin
            n_fail++;
            $display("ERROR %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one selection write; the previous write's count is checked first
    task automatic wr(input int p, input int c, input logic s);
        logic ok;
        @(posedge i_mclk);
        check(16'(o_link_count), 16'(cnt));
        ok = c < (i_e1_mode ? 31 : 24) && !(sel[p][c] != s && s && cnt == 64)
            && !(p % 2 == 1 && i_channelized && i_bridge_en[p/2]);
        i_map_wr <= 1'b1;
        i_map_port <= p[2:0];
        i_map_chan <= c[4:0];
        i_map_set <= s;
        @(posedge i_mclk);
        check({o_map_ack, o_map_refused}, {ok, !ok});
        i_map_wr <= 1'b0;
        if (ok && sel[p][c] != s)
            cnt = s ? cnt + 1 : cnt - 1;
        if (ok)
            sel[p][c] = s;
    endtask
    // bounded wait for a quiet link side
    task automatic wait_idle(input int lim);
        int t;
        t = 0;
        repeat (4) @(posedge i_mclk);
        while ((o_cfg_busy !== 1'b0 || exp_q.size() > 0) && t < lim)
        begin
            @(posedge i_mclk);
            t++;
        end
        if (t == lim)
        begin
            n_fail++;
            complete_run();
        end
    endtask
    // drops are noted in slot order and transmit octets checked a cycle on
    always @(posedge i_lclk)
    begin
        stb_d <= i_ts_strobe;
        slot_d <= slot;
        if (i_ts_strobe)
            for (int p = 0; p < 8; p++)
            begin
                check(16'(o_sig_take[p]), 16'(on(p, slot)));
                if (on(p, slot))
                    exp_q.push_back({slot, p[2:0], rxo(p, slot)});
            end
        if (stb_d)
            for (int p = 0; p < 8; p++)
                check(16'(o_tx_octets[8*p +: 8]), 16'(txo(p, slot_d)));
    end
    // random consumer stalls; each take meets the oldest note
    always @(posedge i_mclk)
    begin
        lfsr <= lfsr_step(lfsr);
        i_rx_ready <= lfsr[0] | lfsr[3];
        if (o_rx_valid === 1'b1 && i_rx_ready)
            check({o_rx_slot, o_rx_port, o_rx_data},
                exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
    end
    // a hang anywhere ends the run as a failure
    initial
    begin
        #800000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        for (int p = 0; p < 8; p++)
            sel[p] = (p == 0) ? 32'h0000FFFF : 32'h00000000;
        repeat (5) @(posedge i_lclk);
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        check(16'(o_iface_active), 16'h0001);
        i_e1_mode <= 1'b1;
        wr(6, 31, 1'b1);
        wr(6, 30, 1'b1);
        @(posedge i_mclk);
        check(16'(o_iface_active), 16'h0003);
        wr(6, 30, 1'b0);
        i_e1_mode <= 1'b0;
        wr(6, 24, 1'b1);
        // fill the budget to sixty-four, then one more is refused
        for (int i = 0; i < 49; i++)
            wr(i < 8 ? 0 : i < 32 ? 2 : 4, i < 8 ? i + 16 : i < 32 ? i - 8 : i - 32,
                1'b1);
        i_bridge_en <= 4'h5;
        @(posedge i_mclk);
        @(posedge i_mclk);
        check(16'(o_bridge_active), 16'h0000);
        i_channelized <= 1'b1;
        @(posedge i_mclk);
        @(posedge i_mclk);
        check(16'(o_bridge_active), 16'h0005);
        for (int i = 0; i < 24; i++)
            wr(lfsr[3:1], lfsr[9:5], lfsr[10]);
        wait_idle(3000);
        line_en <= 1'b1;
        repeat (30000) @(posedge i_mclk);
        line_en <= 1'b0;
        wait_idle(3000);
        check(16'(o_rx_overflow), 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
